// ===== design/strap_pin_capture.sv
// strap_pin_capture: samples the strap pins after hardware or software
// reset, holds the decoded startup configuration, then hands the pins
// back to their normal output function. axi4-lite register port.
// assumes pads resolve a released pin to its weak pull level.
//
// Contract
// - straps undriven while reset is held
// - latch strap levels at reset release
// - drive pins normally after reset release
// - weak pull gives default captured level
// - software reset also resamples all straps
// - management select: 00 mdio, 01 i2c, 1x spi
// - port 6: rgmii, rmii, reserved, mii
// - forward at once, else wait start bit
// - in-band management enabled only when latched 1
`timescale 1ns/1ps

module strap_pin_capture
  import strap_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [NUM_STRAPS-1:0] strap_in,
  output logic [NUM_STRAPS-1:0]      strap_out,
  output logic [NUM_STRAPS-1:0]      strap_oe,
  output logic [NUM_STRAPS-1:0]      strap_pull_up,
  input  wire logic [NUM_STRAPS-1:0] func_out,
  output mgmt_if_e                   mgmt_if,
  output p6_mode_e                   p6_mode,
  output logic                       forward_en,
  output logic                       inband_mgmt_en,
  output logic                       cfg_valid
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser: first stage read only by the second

  logic [NUM_STRAPS-1:0] sync1_ff;
  logic [NUM_STRAPS-1:0] sync2_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_ff <= STRAP_PULL_UP;
      sync2_ff <= STRAP_PULL_UP;
    end
    else
    begin
      sync1_ff <= strap_in;
      sync2_ff <= sync1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register access decode, shared by write and read paths

  function automatic logic hit(input logic [31:0] a,
                               input logic [31:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  logic wr_fire;
  logic rd_fire;
  logic wr_ctrl;
  logic soft_rst_req;

  assign wr_fire      = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
  assign rd_fire      = s_axi_arready & s_axi_arvalid;
  assign wr_ctrl      = wr_fire & hit(s_axi_awaddr, ADDR_CTRL)
                      & s_axi_wstrb[0];
  assign soft_rst_req = wr_ctrl & s_axi_wdata[CTRL_SRST_BIT];

  ////////////////////////////////////////////////////////////////////////
  // capture sequencer

  cap_state_e  state_ff;
  cap_state_e  nxt_state;
  logic [2:0]  cnt_ff;
  logic [2:0]  nxt_cnt;
  strap_cfg_s  cfg_ff;
  strap_cfg_s  nxt_cfg;
  logic        done_ff;
  logic        nxt_done;
  logic        start_ff;
  logic        nxt_start;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_cfg   = cfg_ff;
    nxt_done  = done_ff;
    nxt_start = start_ff;
    if (wr_ctrl)
    begin
      nxt_start = s_axi_wdata[CTRL_START_BIT];
    end
    unique case (state_ff)
      ST_FLOAT:
      begin
        // pins stay released; sync pipeline fills with pull/strap level
        if (cnt_ff == SETTLE_CYC)
        begin
          nxt_cfg   = strap_cfg_s'(sync2_ff);
          nxt_done  = 1'b1;
          nxt_state = ST_RUN;
          nxt_cnt   = 3'h0;
        end
        else
        begin
          nxt_cnt = cnt_ff + 3'h1;
        end
      end
      ST_RUN:
      begin
        // config frozen here; only a reset leaves this state
        if (soft_rst_req)
        begin
          nxt_state = ST_FLOAT;
          nxt_cnt   = 3'h0;
          nxt_done  = 1'b0;
          nxt_start = 1'b0;
        end
      end
      default:
      begin
        nxt_state = ST_FLOAT;
        nxt_cnt   = 3'h0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ST_FLOAT;
      cnt_ff   <= 3'h0;
      cfg_ff   <= strap_cfg_s'(STRAP_PULL_UP);
      done_ff  <= 1'b0;
      start_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      cfg_ff   <= nxt_cfg;
      done_ff  <= nxt_done;
      start_ff <= nxt_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers and decoded configuration outputs

  logic [NUM_STRAPS-1:0] out_ff;
  logic [NUM_STRAPS-1:0] nxt_out;
  logic [NUM_STRAPS-1:0] oe_ff;
  logic [NUM_STRAPS-1:0] nxt_oe;
  mgmt_if_e              mgmt_ff;
  mgmt_if_e              nxt_mgmt;
  p6_mode_e              p6_ff;
  p6_mode_e              nxt_p6;
  logic                  fwd_ff;
  logic                  nxt_fwd;
  logic                  iba_ff;
  logic                  nxt_iba;

  always_comb
  begin
    nxt_out  = func_out;
    // released during the whole float phase, incl. its last cycle
    nxt_oe   = (nxt_state == ST_RUN) ? {NUM_STRAPS{1'b1}}
                                     : {NUM_STRAPS{1'b0}};
    nxt_mgmt = decode_mgmt(nxt_cfg.mgmt_sel);
    nxt_p6   = decode_p6(nxt_cfg.p6_iface);
    // forwarding held off until capture finishes either way
    nxt_fwd  = nxt_done & (nxt_cfg.fwd | nxt_start);
    nxt_iba  = nxt_done & nxt_cfg.inband;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_ff  <= {NUM_STRAPS{1'b0}};
      oe_ff   <= {NUM_STRAPS{1'b0}};
      mgmt_ff <= MGMT_SPI;
      p6_ff   <= P6_RGMII;
      fwd_ff  <= 1'b0;
      iba_ff  <= 1'b0;
    end
    else
    begin
      out_ff  <= nxt_out;
      oe_ff   <= nxt_oe;
      mgmt_ff <= nxt_mgmt;
      p6_ff   <= nxt_p6;
      fwd_ff  <= nxt_fwd;
      iba_ff  <= nxt_iba;
    end
  end

  logic [NUM_STRAPS-1:0] pull_ff;

  always_ff @(posedge aclk)
  begin
    pull_ff <= STRAP_PULL_UP;
  end

  assign strap_out      = out_ff;
  assign strap_oe       = oe_ff;
  assign strap_pull_up  = pull_ff;
  assign mgmt_if        = mgmt_ff;
  assign p6_mode        = p6_ff;
  assign forward_en     = fwd_ff;
  assign inband_mgmt_en = iba_ff;
  assign cfg_valid      = done_ff;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one write and one read outstanding at most

  logic        awr_ff;
  logic        nxt_awr;
  logic        bval_ff;
  logic        nxt_bval;
  logic [1:0]  bresp_ff;
  logic [1:0]  nxt_bresp;
  logic        arr_ff;
  logic        nxt_arr;
  logic        rval_ff;
  logic        nxt_rval;
  logic [1:0]  rresp_ff;
  logic [1:0]  nxt_rresp;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] status_word;

  always_comb
  begin
    status_word = ZERO_WORD;
    status_word[STAT_RAW_LSB +: NUM_STRAPS] = cfg_ff;
    status_word[STAT_DONE_BIT]              = done_ff;
    status_word[STAT_FWD_BIT]               = fwd_ff;
  end

  always_comb
  begin
    nxt_awr   = 1'b0;
    nxt_bval  = bval_ff;
    nxt_bresp = bresp_ff;
    nxt_arr   = 1'b0;
    nxt_rval  = rval_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    // ready only once both channels are offered: takes them together
    if (!awr_ff && !bval_ff && s_axi_awvalid && s_axi_wvalid)
    begin
      nxt_awr = 1'b1;
    end
    if (wr_fire)
    begin
      nxt_bval  = 1'b1;
      nxt_bresp = (hit(s_axi_awaddr, ADDR_CTRL) ||
                   hit(s_axi_awaddr, ADDR_STATUS)) ? RESP_OKAY
                                                   : RESP_SLVERR;
    end
    else if (bval_ff && s_axi_bready)
    begin
      nxt_bval = 1'b0;
    end
    if (!arr_ff && !rval_ff && s_axi_arvalid)
    begin
      nxt_arr = 1'b1;
    end
    if (rd_fire)
    begin
      nxt_rval  = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = ZERO_WORD;
      if (hit(s_axi_araddr, ADDR_CTRL))
      begin
        nxt_rdata[CTRL_START_BIT] = start_ff;
      end
      else if (hit(s_axi_araddr, ADDR_STATUS))
      begin
        nxt_rdata = status_word;
      end
      else
      begin
        nxt_rresp = RESP_SLVERR;
      end
    end
    else if (rval_ff && s_axi_rready)
    begin
      nxt_rval = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awr_ff   <= 1'b0;
      bval_ff  <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arr_ff   <= 1'b0;
      rval_ff  <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= ZERO_WORD;
    end
    else
    begin
      awr_ff   <= nxt_awr;
      bval_ff  <= nxt_bval;
      bresp_ff <= nxt_bresp;
      arr_ff   <= nxt_arr;
      rval_ff  <= nxt_rval;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  assign s_axi_awready = awr_ff;
  assign s_axi_wready  = awr_ff;
  assign s_axi_bvalid  = bval_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arr_ff;
  assign s_axi_rvalid  = rval_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

endmodule : strap_pin_capture

// ===== design/strap_pkg.sv
// strap_pkg: constants, types and decoders for the strap capture block
// assumes a 10 MHz aclk and a 32-bit axi4-lite register port
package strap_pkg;

  localparam int           CLK_PERIOD_NS  = 100;
  // pins float this long after reset so the pulls settle and sync fills
  localparam int           SETTLE_NS      = 300;
  localparam logic [2:0]   SETTLE_CYC     =
    3'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int           NUM_STRAPS     = 6;
  localparam int           IDX_INBAND     = 0;
  localparam int           IDX_FWD        = 1;
  localparam int           IDX_MGMT_LO    = 2;
  localparam int           IDX_MGMT_HI    = 3;
  localparam int           IDX_P6_LO      = 4;
  localparam int           IDX_P6_HI      = 5;
  // weak pull direction per pin, 1 = pull-up; also the captured default
  localparam logic [5:0]   STRAP_PULL_UP  = 6'h0E;

  localparam logic [31:0]  ADDR_CTRL      = 32'h0000_0000;
  localparam logic [31:0]  ADDR_STATUS    = 32'h0000_0004;
  localparam int           CTRL_START_BIT = 0;
  localparam int           CTRL_SRST_BIT  = 1;
  localparam int           STAT_RAW_LSB   = 0;
  localparam int           STAT_DONE_BIT  = 8;
  localparam int           STAT_FWD_BIT   = 9;
  localparam logic [1:0]   RESP_OKAY      = 2'h0;
  localparam logic [1:0]   RESP_SLVERR    = 2'h2;
  localparam logic [31:0]  ZERO_WORD      = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_FLOAT = 2'b01,
    ST_RUN   = 2'b10
  } cap_state_e;

  typedef enum logic [2:0] {
    MGMT_MDIO = 3'b001,
    MGMT_I2C  = 3'b010,
    MGMT_SPI  = 3'b100
  } mgmt_if_e;

  typedef enum logic [3:0] {
    P6_RGMII = 4'b0001,
    P6_RMII  = 4'b0010,
    P6_RSVD  = 4'b0100,
    P6_MII   = 4'b1000
  } p6_mode_e;

  // field order matches the strap index constants above
  typedef struct packed {
    logic [1:0] p6_iface;
    logic [1:0] mgmt_sel;
    logic       fwd;
    logic       inband;
  } strap_cfg_s;

  function automatic mgmt_if_e decode_mgmt(input logic [1:0] sel);
    if (sel[1])
    begin
      decode_mgmt = MGMT_SPI;
    end
    else if (sel[0])
    begin
      decode_mgmt = MGMT_I2C;
    end
    else
    begin
      decode_mgmt = MGMT_MDIO;
    end
  endfunction : decode_mgmt

  function automatic p6_mode_e decode_p6(input logic [1:0] sel);
    unique case (sel)
      2'h0:    decode_p6 = P6_RGMII;
      2'h1:    decode_p6 = P6_RMII;
      2'h2:    decode_p6 = P6_RSVD;
      default: decode_p6 = P6_MII;
    endcase
  endfunction : decode_p6

endpackage : strap_pkg

// ===== verif/strap_board.sv
// strap_board: board-side pulls and strap resistors on the strap pins
// assumes the device drives a pin only while its strap_oe bit is high
`timescale 1ns/1ps

module strap_board
  import strap_pkg::*;
(
  input  wire logic [NUM_STRAPS-1:0] strap_out,
  input  wire logic [NUM_STRAPS-1:0] strap_oe,
  input  wire logic [NUM_STRAPS-1:0] strap_pull_up,
  input  wire logic [NUM_STRAPS-1:0] ext_val,
  input  wire logic [NUM_STRAPS-1:0] ext_en,
  output logic      [NUM_STRAPS-1:0] pin
);
  // a strong board resistor beats the weak internal pull
  always_comb
  begin
    for (int i = 0; i < NUM_STRAPS; i++)
    begin
      pin[i] = strap_oe[i] ? strap_out[i] :
               (ext_en[i] ? ext_val[i] : strap_pull_up[i]);
    end
  end
endmodule : strap_board

// ===== verif/strap_pin_capture_assertions.sv
// strap_pin_capture_assertions: port checks of the strap capture block
// assumes it is bound into strap_pin_capture
`timescale 1ns/1ps

module strap_pin_capture_assertions
  import strap_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic [5:0]  strap_out,
  input wire logic [5:0]  strap_oe,
  input wire logic [5:0]  strap_pull_up,
  input wire logic [5:0]  func_out,
  input wire logic        forward_en,
  input wire logic        cfg_valid,
  input wire mgmt_if_e    mgmt_if,
  input wire p6_mode_e    p6_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RST_FLOAT: assert property (disable iff (1'b0) !aresetn |=>
    strap_oe == 6'h00 && !cfg_valid) else $error("pins driven in reset");
  AST_CAP_TIME: assert property ($rose(aresetn) |->
    !cfg_valid [*3] ##[1:2] cfg_valid) else $error("capture timing");
  AST_OE_DRIVE: assert property (strap_oe == {6{cfg_valid}})
    else $error("pin drive does not follow capture");
  AST_PIN_FUNC: assert property (cfg_valid && $past(cfg_valid) |->
    strap_out == $past(func_out)) else $error("pin value wrong");
  AST_PULL: assert property (strap_pull_up == STRAP_PULL_UP)
    else $error("pull direction wrong");
  AST_HOLD: assert property (cfg_valid && $past(cfg_valid) |->
    $stable(mgmt_if) && $stable(p6_mode)) else $error("config moved");
  AST_SOFT: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0] && s_axi_wdata[1] &&
    cfg_valid |=> !cfg_valid && strap_oe == 6'h00)
    else $error("soft reset did not float pins");
  AST_FWD: assert property (!cfg_valid |-> !forward_en)
    else $error("forwarding before capture");
endmodule : strap_pin_capture_assertions

bind strap_pin_capture strap_pin_capture_assertions u_chk (.aclk,
  .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .strap_out, .strap_oe, .strap_pull_up, .func_out,
  .forward_en, .cfg_valid, .mgmt_if, .p6_mode);

// ===== verif/strap_pin_capture_tb.sv
// strap_pin_capture_tb: directed scenarios over axi4-lite and strap pins
// assumes strap_board resolves pins from pulls and board resistors
`timescale 1ns/1ps

module strap_pin_capture_tb
  import strap_pkg::*;
;
  logic        aclk, aresetn, forward_en, inband_mgmt_en, cfg_valid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  strap_in, strap_out, strap_oe, strap_pull_up, func_out;
  logic [5:0]  ext_val, ext_en;
  mgmt_if_e    mgmt_if;
  p6_mode_e    p6_mode;
  int          error_cnt, n_compared;
  mgmt_if_e    mgmt_tab [4] = '{MGMT_MDIO, MGMT_I2C, MGMT_SPI, MGMT_SPI};
  p6_mode_e    p6_tab [4] = '{P6_RGMII, P6_RMII, P6_RSVD, P6_MII};

  strap_pin_capture i_dut (.*);
  strap_board i_board (.strap_out, .strap_oe, .strap_pull_up, .ext_val,
    .ext_en, .pin(strap_in));

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // one write, address and data offered together, each dropped when taken;
  // waits with no limit of its own, the watchdog ends a hang
  task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] r);
    bit aw_open;
    bit w_open;
    aw_open = 1'b1;
    w_open  = 1'b1;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (aw_open || w_open)
    begin
      @(posedge aclk);
      if (aw_open && s_axi_awready === 1'b1)
      begin
        s_axi_awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && s_axi_wready === 1'b1)
      begin
        s_axi_wvalid <= 1'b0;
        w_open = 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    check(s_axi_bresp, r);
    s_axi_bready  <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    check(s_axi_rdata, d);
    check(s_axi_rresp, r);
    s_axi_rready  <= 1'b0;
  endtask : axi_rd

  task automatic hw_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    check(strap_oe, 6'h00);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : hw_reset

  // bounded wait; a capture that never comes shows as a mismatch
  task automatic wait_cap();
    for (int n = 0; n < 20 && cfg_valid !== 1'b1; n++) @(posedge aclk);
    check(cfg_valid, 1'b1);
  endtask : wait_cap

  ////////////////////////////////////////////////////////////////////////
  task automatic t_default();
    hw_reset();
    wait_cap();
    check({mgmt_if, p6_mode, forward_en, inband_mgmt_en},
          {MGMT_SPI, P6_RGMII, 2'b10});
    axi_rd(ADDR_STATUS, 32'h0000_030E, RESP_OKAY);
  endtask : t_default

  // every strap code, resampled by software reset
  task automatic t_codes();
    for (int i = 0; i < 4; i++)
    begin
      ext_en  <= 6'h3F;
      ext_val <= {2'(i), 2'(i), i[0], i[1]};
      axi_wr(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
      wait_cap();
      check(mgmt_if, mgmt_tab[i]);
      check(p6_mode, p6_tab[i]);
      check({forward_en, inband_mgmt_en}, {i[0], i[1]});
      if (!i[0])
      begin
        axi_wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
        @(posedge aclk);
        check(forward_en, 1'b1);
      end
    end
  endtask : t_codes

  task automatic t_hold();
    ext_val  <= 6'h00;
    func_out <= 6'h15;
    repeat (3) @(posedge aclk);
    check({strap_oe, strap_in}, {6'h3F, 6'h15});
    axi_rd(ADDR_STATUS, 32'h0000_033F, RESP_OKAY);
    axi_rd(32'h0000_0010, ZERO_WORD, RESP_SLVERR);
    axi_wr(32'h0000_0010, 32'h0000_0002, RESP_SLVERR);
    check(cfg_valid, 1'b1);
  endtask : t_hold

  task automatic t_hw();
    ext_val <= 6'h06;
    hw_reset();
    wait_cap();
    check({mgmt_if, p6_mode}, {MGMT_I2C, P6_RGMII});
    axi_rd(ADDR_STATUS, 32'h0000_0306, RESP_OKAY);
  endtask : t_hw

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = {3{ZERO_WORD}};
    s_axi_wstrb = 4'hF;
    {func_out, ext_val, ext_en} = {3{6'h00}};
    t_default();
    t_codes();
    t_hold();
    t_hw();
    give_verdict();
  end
endmodule : strap_pin_capture_tb
